// ---- core/iof_formatter.sv ----
// inclination output formatter: averaging, formatting, process data and apb registers
// Notes on behaviour
// - running mean of last 1000 millisecond samples
// - over range plus margin outputs 4650 code
// - full rotation counts to 35999 then wraps
// - yaw rate in bytes six and seven
// - x, y, z little endian in bytes 0-5
// - full resolution; range only moves threshold
// - cross tilt above 30 degrees overflows
// - acceleration output as signed counts per g
// - zero offset limited to five degrees
// - default counter clockwise, reversible to clockwise
// - two transmit objects, four trigger modes
// - one read/write configuration channel
// - master assigns node id, device adopts
// - bit rate starts at 20 kbaud
module iof_formatter import iof_pkg::*; #(
   parameter int TICK_CYCLES = TICK_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // sensor samples
   input wire iof_samp_s samp,
   // network side
   input wire logic sync_pulse,
   output logic [1:0] tpdo_valid,
   input wire logic [1:0] tpdo_ready,
   output iof_payload_s tpdo_data,
   output logic [6:0] node_id,
   output logic [3:0] baud_sel,
   // interrupt
   output logic irq
);
   localparam int TW = $clog2(TICK_CYCLES + 1);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   iof_state_e state_q; // sequencer
   logic [TW-1:0] tick_q; // millisecond divider
   logic tick; // sample strobe
   iof_samp_s samp_q; // captured sample
   logic [PTR_W-1:0] wptr_q; // oldest entry
   logic [PTR_W:0] fill_q; // samples held
   logic full_q; // history complete
   logic out_ok_q; // payload valid to send
   logic [3*AX_W-1:0] old_vec; // sample leaving window
   logic [3*AX_W-1:0] new_vec; // sample entering
   logic signed [SUM_W-1:0] sum_q [AXES];
   logic signed [AX_W-1:0] mean_q [AXES];
   logic [AX_W-1:0] out_d [AXES]; // formatted words
   logic [AXES-1:0] ovr; // over range per axis
   logic signed [17:0] v_dir [AXES]; // after offset and direction
   iof_payload_s payload_q; // last formatted frame
   logic changed_q; // frame differs from previous
   logic [6:0] ctrl_q;
   logic [6:0] range_q;
   logic signed [15:0] ofs_q;
   logic [31:0] pdo_cfg_q;
   logic [STAT_W-1:0] stat_q;
   logic [STAT_W-1:0] mask_q;
   logic [STAT_W-1:0] stat_set;
   logic [15:0] cyc_q; // cyclic period counter, in ms
   logic cyc_hit;
   logic [1:0] pend_q; // transmit requests outstanding
   logic [1:0] chg_q; // change seen since last acyclic send
   logic [1:0] ev; // transmit events this cycle
   logic wr_acc; // apb write taken
   logic hit; // address is mapped
   logic [13:0] thr; // over range threshold
   logic signed [15:0] wofs; // offset candidate

   // ----------------------------------------
   // millisecond sample tick
   // ----------------------------------------
   assign tick = (tick_q == TW'(TICK_CYCLES - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_q <= '0;
      end else if (tick) begin
         tick_q <= '0;
      end else begin
         tick_q <= tick_q + 1'b1;
      end
   end

   // ----------------------------------------
   // sequencer: one pass per sample
   // ----------------------------------------
   // one sample per ms
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= IOF_IDLE;
      end else begin
         unique case (state_q)
            IOF_IDLE: if (tick) state_q <= IOF_ACCUM;
            IOF_ACCUM: state_q <= IOF_MEAN;
            IOF_MEAN: state_q <= IOF_FORMAT;
            IOF_FORMAT: state_q <= IOF_SEND;
            IOF_SEND: state_q <= IOF_IDLE;
         endcase
      end
   end

   // capture the sample on the tick; inputs are synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         samp_q <= '0;
      end else if (state_q == IOF_IDLE && tick) begin
         samp_q <= samp;
      end
   end

   // ----------------------------------------
   // history window
   // ----------------------------------------
   assign new_vec = {samp_q.z, samp_q.y, samp_q.x};

   // oldest entry is read on the tick and overwritten one cycle later
   iof_avg_mem #(.W(3 * AX_W), .D(AVG_DEPTH), .AW(PTR_W)) u_hist (
      .clk(pclk),
      .wr_en(state_q == IOF_ACCUM),
      .wr_addr(wptr_q),
      .wr_data(new_vec),
      .rd_en(state_q == IOF_IDLE && tick),
      .rd_addr(wptr_q),
      .rd_data(old_vec)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wptr_q <= '0;
         fill_q <= '0;
         full_q <= 1'b0;
      end else if (state_q == IOF_ACCUM) begin
         wptr_q <= (wptr_q == PTR_W'(AVG_DEPTH - 1)) ? '0 : wptr_q + 1'b1;
         if (!full_q) begin
            fill_q <= fill_q + 1'b1;
            full_q <= (fill_q == (PTR_W + 1)'(AVG_DEPTH - 1));
         end
      end
   end

   // ----------------------------------------
   // per axis: sum, mean and formatting
   // ----------------------------------------
   assign thr = 14'(range_q * DEG_SCALE) + OVR_MARGIN;

   for (genvar a = 0; a < AXES; a++) begin : g_ax
      logic signed [AX_W-1:0] old_s; // unwritten entries count as zero
      logic signed [PROD_W-1:0] prod;
      logic signed [17:0] v_ofs, mag, rot, crs, other, coarse;
      logic signed [33:0] div;
      logic crossed;
      assign old_s = full_q ? old_vec[a*AX_W +: AX_W] : '0;

      // running sum, new in, oldest out
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            sum_q[a] <= '0;
         end else if (state_q == IOF_ACCUM) begin
            sum_q[a] <= sum_q[a] + SUM_W'($signed(new_vec[a*AX_W +: AX_W])) - SUM_W'(old_s);
         end
      end

      // divide by the depth through a reciprocal
      assign prod = PROD_W'(sum_q[a]) * PROD_W'($signed({1'b0, MEAN_K}));
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            mean_q[a] <= '0;
         end else if (state_q == IOF_MEAN) begin
            mean_q[a] <= AX_W'(prod >>> MEAN_SH);
         end
      end

      assign v_ofs = 18'(mean_q[a]) + 18'(ofs_q);
      assign v_dir[a] = ctrl_q[CB_DIR_CW] ? -v_ofs : v_ofs;
      assign mag = (v_dir[a] < 0) ? -v_dir[a] : v_dir[a];
      assign rot = (v_dir[a] < 0) ? v_dir[a] + $signed(ROT_SPAN) :
                   (v_dir[a] > $signed(ROT_MAX)) ? v_dir[a] - $signed(ROT_SPAN) : v_dir[a];
      // x and y watch each other; z has no partner
      assign other = 18'((a == 0) ? mean_q[1] : mean_q[0]);
      assign crs = (other < 0) ? -other : other;
      assign crossed = (a < 2) && !ctrl_q[CB_XCORR] && (crs > $signed(CROSS_LIM));
      // range only sets the threshold, never the scale
      // range plus margin gives over range
      assign ovr[a] = !ctrl_q[CB_ACCEL] && !ctrl_q[CB_FULL_ROT] && ((mag > $signed(18'(thr))) || crossed);
      // coarse 0.1 degree only with scaling on
      assign div = 34'(v_dir[a]) * 34'($signed({1'b0, DIV10_K}));
      assign coarse = 18'(div >>> DIV10_SH);

      always_comb begin
         if (ctrl_q[CB_ACCEL]) begin
            // counts per g pass through unchanged
            out_d[a] = mean_q[a];
         end else if (ctrl_q[CB_FULL_ROT]) begin
            out_d[a] = rot[AX_W-1:0];
         end else if (ovr[a]) begin
            out_d[a] = OVR_CODE;
         end else if (ctrl_q[CB_SCALE] && ctrl_q[CB_COARSE]) begin
            out_d[a] = coarse[AX_W-1:0];
         end else begin
            out_d[a] = v_dir[a][AX_W-1:0];
         end
      end
   end

   // ----------------------------------------
   // payload framing
   // ----------------------------------------
   // x low word, then y, then z
   // yaw rate last, zero when not fitted
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         payload_q <= '0;
         changed_q <= 1'b0;
      end else if (state_q == IOF_FORMAT) begin
         payload_q <= {ctrl_q[CB_GYRO] ? samp_q.rate : 16'h0000, out_d[2], out_d[1], out_d[0]};
         changed_q <= ({ctrl_q[CB_GYRO] ? samp_q.rate : 16'h0000, out_d[2], out_d[1], out_d[0]} != payload_q);
      end
   end

   // nothing sent before the first full mean
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_ok_q <= 1'b0;
      end else if (state_q == IOF_SEND && full_q) begin
         out_ok_q <= 1'b1;
      end
   end

   // ----------------------------------------
   // transmit objects
   // ----------------------------------------
   assign cyc_hit = (state_q == IOF_SEND) && (pdo_cfg_q[31:16] != 16'h0000) && (cyc_q >= pdo_cfg_q[31:16] - 1'b1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cyc_q <= '0;
      end else if (cyc_hit) begin
         cyc_q <= '0;
      end else if (state_q == IOF_SEND) begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   for (genvar p = 0; p < 2; p++) begin : g_pdo
      logic [1:0] mode;
      logic fresh;
      assign mode = pdo_cfg_q[2*p +: 2];
      assign fresh = (state_q == IOF_SEND) && changed_q;
      assign ev[p] = out_ok_q && (((mode == PM_SYNC) && sync_pulse) ||
                                  ((mode == PM_ACYC) && sync_pulse && chg_q[p]) ||
                                  ((mode == PM_ASYNC) && fresh) ||
                                  ((mode == PM_CYCLIC) && cyc_hit));
      // a new request wins over the taking of the old one
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            pend_q[p] <= 1'b0;
            chg_q[p] <= 1'b0;
         end else begin
            pend_q[p] <= ev[p] | (pend_q[p] & ~tpdo_ready[p]);
            chg_q[p] <= fresh | (chg_q[p] & ~ev[p]);
         end
      end
   end
   assign tpdo_valid = pend_q;

   // data held while any request waits, so a frame never changes mid offer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tpdo_data <= '0;
      end else if ((|ev) && !(|pend_q)) begin
         tpdo_data <= payload_q;
      end
   end

   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   // the bus is the single configuration channel
   assign wr_acc = psel && penable && pwrite;
   assign pready = 1'b1;
   assign wofs = pwdata[15:0];
   assign hit = (paddr <= A_FILL) && (paddr[1:0] == 2'b00);
   assign pslverr = psel && penable && !hit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         range_q <= RANGE_RST;
         ofs_q <= '0;
         pdo_cfg_q <= '0;
         mask_q <= '0;
      end else if (wr_acc) begin
         if (paddr == A_CTRL) ctrl_q <= pwdata[6:0];
         if (paddr == A_RANGE) range_q <= pwdata[6:0];
         if (paddr == A_OFS && wofs <= $signed(OFS_LIM) && wofs >= -$signed(OFS_LIM)) ofs_q <= wofs;
         if (paddr == A_PDO) pdo_cfg_q <= pwdata;
         if (paddr == A_MASK) mask_q <= pwdata[STAT_W-1:0];
      end
   end

   // legal node ids adopted at once
   // bit rate index starts at 20 kbaud
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         node_id <= NODE_RST;
         baud_sel <= BAUD_20K;
      end else if (wr_acc) begin
         if (paddr == A_NODE && pwdata[6:0] != 7'h00) node_id <= pwdata[6:0];
         if (paddr == A_BAUD) baud_sel <= pwdata[3:0];
      end
   end

   // ----------------------------------------
   // status and interrupt
   // ----------------------------------------
   always_comb begin
      stat_set = '0;
      stat_set[SB_NEW] = (state_q == IOF_SEND) && full_q;
      stat_set[SB_OVR] = (state_q == IOF_FORMAT) && (|ovr);
      stat_set[SB_OFS_REJ] = wr_acc && (paddr == A_OFS) && (wofs > $signed(OFS_LIM) || wofs < -$signed(OFS_LIM));
      stat_set[SB_NODE_REJ] = wr_acc && (paddr == A_NODE) && (pwdata[6:0] == 7'h00 || pwdata[31:7] != '0);
   end

   // write one to clear; a set in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~((wr_acc && paddr == A_STAT) ? pwdata[STAT_W-1:0] : '0)) | stat_set;
      end
   end
   assign irq = |(stat_q & mask_q);

   // read mux, registers only
   always_comb begin
      prdata = 32'h0000_0000;
      if (psel && !pwrite) begin
         unique case (paddr)
            A_CTRL: prdata = {25'h0, ctrl_q};
            A_RANGE: prdata = {25'h0, range_q};
            A_OFS: prdata = {16'h0000, ofs_q};
            A_NODE: prdata = {25'h0, node_id};
            A_BAUD: prdata = {28'h0, baud_sel};
            A_PDO: prdata = pdo_cfg_q;
            A_STAT: prdata = {28'h0, stat_q};
            A_MASK: prdata = {28'h0, mask_q};
            A_OUT_LO: prdata = payload_q[31:0];
            A_OUT_HI: prdata = payload_q[63:32];
            A_FILL: prdata = {20'h0, full_q, fill_q};
            default: prdata = 32'h0000_0000;
         endcase
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_pass;
      state_q == IOF_ACCUM ##1 state_q == IOF_MEAN ##1 state_q == IOF_FORMAT ##1 state_q == IOF_SEND;
   endsequence
   avg_pass_a: assert property (state_q == IOF_IDLE && tick |=> s_pass) else $error("sample pass broken");
   ptr_wrap_a: assert property (state_q == IOF_ACCUM && wptr_q == PTR_W'(AVG_DEPTH - 1) |=> wptr_q == '0)
      else $error("window pointer did not wrap");
   ovr_code_a: assert property (state_q == IOF_FORMAT && ovr[0] |=> payload_q.x == OVR_CODE)
      else $error("over range code missing");
   rot_bound_a: assert property (ctrl_q[CB_FULL_ROT] && state_q == IOF_SEND |-> payload_q.x <= ROT_MAX[15:0])
      else $error("rotation value above 35999");
   yaw_place_a: assert property (state_q == IOF_FORMAT && ctrl_q[CB_GYRO] |=> payload_q.rate == $past(samp_q.rate))
      else $error("yaw rate misplaced");
   ofs_reject_a: assert property (stat_set[SB_OFS_REJ] |=> $stable(ofs_q) && stat_q[SB_OFS_REJ])
      else $error("oversized offset taken");
   early_send_a: assert property (!full_q |-> tpdo_valid == 2'b00) else $error("frame before full window");
   pdo_hold_a: assert property (tpdo_valid[0] && !tpdo_ready[0] |=> tpdo_valid[0] && $stable(tpdo_data))
      else $error("offered frame dropped or changed");
   node_take_a: assert property (wr_acc && paddr == A_NODE && pwdata[6:0] != 7'h00 |=> node_id == $past(pwdata[6:0]))
      else $error("node id not adopted");
   baud_keep_a: assert property (!(wr_acc && paddr == A_BAUD) |=> $stable(baud_sel))
      else $error("bit rate changed without write");
endmodule

// ---- core/iof_pkg.sv ----
// package: constants, carriers and states of the inclination output formatter
package iof_pkg;
   // ----------------------------------------
   // averaging
   // ----------------------------------------
   localparam int AX_W = 16;
   localparam int AXES = 3;
   localparam int AVG_DEPTH = 1000;
   localparam int PTR_W = 10;
   localparam int SUM_W = 26;
   localparam int PROD_W = 48;
   localparam logic [21:0] MEAN_K = 22'h10624e; // 2^30 / 1000, rounded
   localparam int MEAN_SH = 30;
   // ----------------------------------------
   // timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int SAMPLE_PERIOD_NS = 1000000;
   localparam int TICK_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   // ----------------------------------------
   // value formatting, units of 0.01 degree
   // ----------------------------------------
   localparam logic [15:0] OVR_CODE = 16'h4650;
   localparam logic [17:0] ROT_MAX = 18'h08c9f;
   localparam logic [17:0] ROT_SPAN = 18'h08ca0;
   localparam logic [13:0] DEG_SCALE = 14'h0064;
   localparam logic [13:0] OVR_MARGIN = 14'h00c8;
   localparam logic [17:0] CROSS_LIM = 18'h00bb8;
   localparam logic [15:0] OFS_LIM = 16'h01f4;
   localparam logic [15:0] DIV10_K = 16'h199a;
   localparam int DIV10_SH = 16;
   // ----------------------------------------
   // network settings and measuring range reset
   // ----------------------------------------
   localparam logic [6:0] NODE_RST = 7'h01;
   localparam logic [3:0] BAUD_20K = 4'h7;
   localparam logic [6:0] RANGE_RST = 7'h5a;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_RANGE = 8'h04;
   localparam logic [7:0] A_OFS = 8'h08;
   localparam logic [7:0] A_NODE = 8'h0c;
   localparam logic [7:0] A_BAUD = 8'h10;
   localparam logic [7:0] A_PDO = 8'h14;
   localparam logic [7:0] A_STAT = 8'h18;
   localparam logic [7:0] A_MASK = 8'h1c;
   localparam logic [7:0] A_OUT_LO = 8'h20;
   localparam logic [7:0] A_OUT_HI = 8'h24;
   localparam logic [7:0] A_FILL = 8'h28;
   // control bits
   localparam int CB_DIR_CW = 0;
   localparam int CB_COARSE = 1;
   localparam int CB_SCALE = 2;
   localparam int CB_FULL_ROT = 3;
   localparam int CB_ACCEL = 4;
   localparam int CB_GYRO = 5;
   localparam int CB_XCORR = 6;
   // status bits
   localparam int STAT_W = 4;
   localparam int SB_NEW = 0;
   localparam int SB_OVR = 1;
   localparam int SB_OFS_REJ = 2;
   localparam int SB_NODE_REJ = 3;
   // process data transmit modes
   localparam logic [1:0] PM_SYNC = 2'h0;
   localparam logic [1:0] PM_ACYC = 2'h1;
   localparam logic [1:0] PM_ASYNC = 2'h2;
   localparam logic [1:0] PM_CYCLIC = 2'h3;
   // ----------------------------------------
   // carriers and states
   // ----------------------------------------
   typedef struct packed {
      logic signed [AX_W-1:0] rate;
      logic signed [AX_W-1:0] z;
      logic signed [AX_W-1:0] y;
      logic signed [AX_W-1:0] x;
   } iof_samp_s;
   typedef struct packed {
      logic [AX_W-1:0] rate;
      logic [AX_W-1:0] z;
      logic [AX_W-1:0] y;
      logic [AX_W-1:0] x;
   } iof_payload_s;
   typedef enum logic [4:0] {
      IOF_IDLE = 5'h01,
      IOF_ACCUM = 5'h02,
      IOF_MEAN = 5'h04,
      IOF_FORMAT = 5'h08,
      IOF_SEND = 5'h10
   } iof_state_e;
endpackage

// ---- core/iof_avg_mem.sv ----
// sample history memory with registered read data
module iof_avg_mem #(
   parameter int W = 48,
   parameter int D = 1000,
   parameter int AW = 10
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [W-1:0] wr_data,
   // read port
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [W-1:0] rd_data
);
   // storage; contents are undefined until written
   logic [W-1:0] mem [D];

   // write side
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // read side, one cycle of latency
   always_ff @(posedge clk) begin
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// ---- test/iof_master_model.sv ----
// network master stand-in: sync source and transmit object consumer
module iof_master_model import iof_pkg::*; (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // transmit objects
   input wire logic [1:0] tpdo_valid,
   input wire iof_payload_s tpdo_data,
   output logic [1:0] tpdo_ready,
   output logic sync_pulse,
   // observed traffic
   output logic [15:0] rx0_cnt,
   output iof_payload_s rx_frame
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // sync source and consumer
   // ----------------------------------------
   logic [5:0] sync_q; // sync period counter, one pulse per 64 cycles
   logic [2:0] wait_q; // random acceptance delay, so slow answers occur too
   // sync pulse every 64 cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_q <= '0;
         sync_pulse <= 1'b0;
      end else begin
         sync_q <= sync_q + 6'h01;
         sync_pulse <= (sync_q == 6'h00);
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tpdo_ready <= 2'h0;
         wait_q <= 3'h0;
         rx0_cnt <= 16'h0;
         rx_frame <= '0;
      end else begin
         // ready only after the delay has run out
         tpdo_ready <= {2{wait_q == 3'h0}};
         if (wait_q != 3'h0) begin
            wait_q <= wait_q - 3'h1;
         end
         // a taken frame restarts a random wait
         if ((tpdo_valid & tpdo_ready) != 2'h0) begin
            tpdo_ready <= 2'h0;
            wait_q <= 3'($urandom % 6);
            rx_frame <= tpdo_data;
         end
         if (tpdo_valid[0] && tpdo_ready[0]) begin
            rx0_cnt <= rx0_cnt + 16'h1;
         end
      end
   end
endmodule

// ---- test/inclination_output_formatter_bench.sv ----
// self-checking bench of the inclination output formatter
module inclination_output_formatter_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import iof_pkg::*;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   localparam int TICKS = 8; // short tick so the window fills in 8000 cycles
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd_v;
   logic pready, pslverr, sync_pulse, irq, early = 0;
   iof_samp_s samp = '0;
   logic [1:0] tpdo_valid, tpdo_ready;
   iof_payload_s tpdo_data, rx_frame;
   logic [6:0] node_id;
   logic [3:0] baud_sel;
   logic [15:0] rx0_cnt, n0, x, y, z, r, cx, cy;
   int bad_count = 0, n_compared = 0, cyc = 0;
   logic [33:0] exp_q[$]; // notes: {check, pslverr, prdata}
   logic [33:0] e;
   always #2.5 pclk = ~pclk;
   iof_formatter #(.TICK_CYCLES(TICKS)) u_iof_formatter (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .samp(samp), .sync_pulse(sync_pulse), .tpdo_valid(tpdo_valid),
      .tpdo_ready(tpdo_ready), .tpdo_data(tpdo_data), .node_id(node_id), .baud_sel(baud_sel), .irq(irq));
   iof_master_model u_iof_master_model (.pclk(pclk), .presetn(presetn), .tpdo_valid(tpdo_valid),
      .tpdo_data(tpdo_data), .tpdo_ready(tpdo_ready), .sync_pulse(sync_pulse), .rx0_cnt(rx0_cnt),
      .rx_frame(rx_frame));
   // ----------------------------------------
   // checking and bus tasks
   // ----------------------------------------
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      n_compared++;
      if (seen !== want) begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // one apb transfer; a read leaves its note in the queue
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] ex);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      if (!w) exp_q.push_back(ex);
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, '0);
   endtask
   // wait for two fresh frames so the new settings have surely landed
   task automatic wait_new();
      repeat (2) begin
         wr(A_STAT, 32'h1);
         do apb(1'b0, A_STAT, 32'h0, '0); while (rd_v[SB_NEW] !== 1'b1);
      end
   endtask
   task automatic frame(input logic [7:0] c, input logic [6:0] rg, input logic [15:0] o, input logic [31:0] lo,
                        input logic [33:0] hi);
      wr(A_CTRL, {24'h0, c});
      wr(A_RANGE, {25'h0, rg});
      wr(A_OFS, {16'h0, o});
      wait_new();
      apb(1'b0, A_OUT_LO, 32'h0, {2'b10, lo});
      apb(1'b0, A_OUT_HI, 32'h0, hi);
   endtask
   // read monitor takes the oldest note at each completed read
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 9 && cyc < 7900 && tpdo_valid !== 2'b00) early = 1'b1;
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         e = exp_q.pop_front();
         if (e[33]) check({1'b1, pslverr, prdata}, e);
      end
      // hang guard, far above the expected 9600 cycles
      if (cyc > 30000) begin
         bad_count++;
         final_report();
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(32'heb1d));
      x = 16'd3001 + 16'($urandom % 500);
      y = 16'd1 + 16'($urandom % 1100);
      z = 16'd1 + 16'($urandom % 1100);
      r = 16'($urandom % 32767);
      cx = 16'((32'(x) * 32'd6554) >> 16);
      cy = 16'((32'(y) * 32'd6554) >> 16);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      samp <= '{rate: r, z: z, y: y, x: x};
      @(negedge pclk);
      check({27'h0, node_id}, 34'h1);
      check({30'h0, baud_sel}, 34'h7);
      apb(1'b0, A_BAUD, 32'h0, {2'b10, 32'h7});
      apb(1'b0, A_RANGE, 32'h0, {2'b10, 32'h5a});
      apb(1'b0, 8'h2c, 32'h0, {2'b11, 32'h0});
      // refused settings raise masked status bits
      wr(A_MASK, 32'hc);
      wr(A_STAT, 32'hf);
      wr(A_OFS, 32'h1f4);
      apb(1'b0, A_OFS, 32'h0, {2'b10, 32'h1f4});
      @(negedge pclk);
      check({33'h0, irq}, 34'h0);
      wr(A_OFS, 32'hfe0b);
      @(negedge pclk);
      check({33'h0, irq}, 34'h1);
      wr(A_STAT, 32'h4);
      @(negedge pclk);
      check({33'h0, irq}, 34'h0);
      wr(A_NODE, 32'h0);
      @(negedge pclk);
      check({33'h0, irq}, 34'h1);
      apb(1'b0, A_NODE, 32'h0, {2'b10, 32'h1});
      wr(A_STAT, 32'h8);
      wr(A_NODE, 32'h5);
      @(negedge pclk);
      check({27'h0, node_id}, 34'h5);
      check({33'h0, irq}, 34'h0);
      // full window of constant samples
      // full flag sits just above the 11-bit fill count
      do apb(1'b0, A_FILL, 32'h0, '0); while (rd_v[11] !== 1'b1);
      check({33'h0, early}, 34'h0);
      frame(8'h20, 7'd90, 16'h0, {OVR_CODE, x}, {2'b10, r, z});
      frame(8'h60, 7'd90, 16'h0, {y, x}, {2'b10, r, z});
      frame(8'h60, 7'd90, 16'h1f4, {y + 16'd500, x + 16'd500}, '0);
      frame(8'h61, 7'd90, 16'h0, {16'h0 - y, 16'h0 - x}, '0);
      frame(8'h66, 7'd90, 16'h0, {cy, cx}, '0);
      frame(8'h60, 7'd20, 16'h0, {y, OVR_CODE}, {2'b10, r, z});
      frame(8'h49, 7'd90, 16'h0, {16'h8ca0 - y, 16'h8ca0 - x}, '0);
      frame(8'h10, 7'd20, 16'h0, {y, x}, '0);
      // every transmit trigger mode on both objects
      for (int m = 0; m < 4; m++) begin
         wr(A_PDO, {16'h1, 12'h0, 2'(m), 2'(m)});
         // let frames still pending from the previous mode drain first
         repeat (20) @(posedge pclk);
         n0 = rx0_cnt;
         repeat (280) @(posedge pclk);
         // a constant frame gives acyclic and change-driven modes nothing to send
         check({33'h0, rx0_cnt != n0}, {33'h0, m == 0 || m == 3});
      end
      check({2'b10, rx_frame[31:0]}, {2'b10, y, x});
      final_report();
   end
endmodule
